// [pkg/sar_seq_pkg.sv]
package sar_seq_pkg;
  // ---------------------------------------------------------------------------
  // resolution and code points
  // ---------------------------------------------------------------------------
  localparam int unsigned RES_BITS     = 16;
  localparam logic [15:0] CODE_ZERO    = 16'h0000;
  localparam logic [15:0] CODE_MID     = 16'h8000;
  localparam logic [15:0] CODE_FULL    = 16'hffff;
  localparam logic [4:0]  MSB_INDEX    = 5'h0f;

  // ---------------------------------------------------------------------------
  // timing: conversion clock divider and switch settle times
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned SETTLE_NS       = 40;
  localparam int unsigned SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_DIV_CYCLES = 2;

  // ---------------------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b000,
    ST_OPEN   = 3'b001,
    ST_GROUND = 3'b010,
    ST_TEST   = 3'b011,
    ST_DONE   = 3'b100
  } seq_state_t;
endpackage

// [hw/sar_conversion_sequencer.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - a rising edge on convert_start_input after acquisition ends acquisition and starts a conversion.
// - at conversion start the ground switches open first, then both arrays leave the inputs for ground.
// - sixteen binary-weighted elements are tried from msb down to lsb, smallest step one part in 65,536.
// - after the last bit the device returns to acquisition, presents the code and pulses busy-done.
// - bit decisions are paced by an internal conversion tick, independent of any serial clock.
// - the result is straight binary, 0000 at zero, 8000 at half reference, ffff one step below full scale.
// - an input above the reference range yields ffff, never a wrapped code.
// - an input below ground yields 0000.
// - the presented result belongs to the sample taken at the same conversion's start edge.
// - conversion circuitry is powered down between conversions.
module sar_conversion_sequencer
  import sar_seq_pkg::*;
#(
  parameter int unsigned BITS     = RES_BITS,
  parameter int unsigned DIV      = CONV_DIV_CYCLES,
  parameter int unsigned SETTLE   = SETTLE_CYCLES
) (
  input  wire logic            clk,
  input  wire logic            reset_n,
  input  wire logic            clk_en,
  input  wire logic            convert_start_input,
  input  wire logic            comp_above,
  input  wire logic            over_range,
  input  wire logic            under_range,
  output logic                 pos_array_ground_switch,
  output logic                 neg_array_ground_switch,
  output logic                 array_to_input,
  output logic [BITS-1:0]      dac_bits,
  output logic                 conv_power_on,
  output logic                 busy,
  output logic                 conv_done,
  output logic [BITS-1:0]      result_code
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  seq_state_t        state_q,  state_d;
  logic              cnv_q;
  logic [7:0]        tick_cnt_q;
  logic [4:0]        bit_idx_q;
  logic [BITS-1:0]   trial_q;
  logic              gnd_sw_q;
  logic              to_in_q;
  logic              pwr_q;
  logic              busy_q;
  logic              done_q;
  logic [BITS-1:0]   code_q;

  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  // one-hot mask of the bit under test
  function automatic logic [BITS-1:0] bit_mask(input logic [4:0] idx);
    bit_mask = {{(BITS-1){1'b0}}, 1'b1} << idx;
  endfunction

  // edge detector against the last sampled level; cnv_q resets low, so a start
  // level already high at reset release counts as a fresh edge
  wire            start_edge = convert_start_input & ~cnv_q;
  wire            idle       = (state_q == ST_SLEEP);
  wire            launch     = start_edge & idle;
  wire            in_test    = (state_q == ST_TEST);
  wire            tick       = (tick_cnt_q == 8'(DIV - 1));
  wire            settle_end = (tick_cnt_q == 8'(SETTLE - 1));
  wire            last_bit   = (bit_idx_q == 5'h00);
  wire            bit_tick   = in_test & tick;
  wire            final_tick = bit_tick & last_bit;
  // next-state decodes shared by the switch, power and tick counter registers
  wire            will_sleep = (state_d == ST_SLEEP);
  wire            will_open  = (state_d == ST_OPEN);
  wire            moving     = (state_d != state_q);
  wire [4:0]      lower_idx  = 5'(bit_idx_q - 5'h01);
  wire [BITS-1:0] cur_mask   = bit_mask(bit_idx_q);
  // comparator says the trial overshoots: drop this bit
  wire [BITS-1:0] kept_trial = comp_above ? (trial_q & ~cur_mask) : trial_q;
  // the next lower weight is tried in the same tick that decides this one
  wire [BITS-1:0] next_trial = last_bit ? kept_trial : (kept_trial | bit_mask(lower_idx));
  // clamp out-of-range samples; the flags are latched at the sampling edge
  wire [BITS-1:0] final_code = over_range  ? BITS'(CODE_FULL) :
                               under_range ? BITS'(CODE_ZERO) :
                               kept_trial;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  // settle waits use the shared tick counter; the done state lasts one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP:  if (launch) state_d = ST_OPEN;
      ST_OPEN:   if (settle_end) state_d = ST_GROUND;
      ST_GROUND: if (settle_end) state_d = ST_TEST;
      ST_TEST:   if (final_tick) state_d = ST_DONE;
      ST_DONE:   state_d = ST_SLEEP;
      default:   state_d = ST_SLEEP;
    endcase
  end

  // ---------------------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------------------
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_SLEEP;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // last sampled start level; frozen with clk_en, so an edge held off by a
  // low enable is still seen once the enable returns
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnv_q <= 1'b0;
    end else if (clk_en) begin
      cnv_q <= convert_start_input;
    end
  end

  // the tick counter is shared by settle waits and the bit clock; it only
  // runs while awake so the divider also sleeps between conversions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (idle || moving || bit_tick)
        tick_cnt_q <= 8'h00;
      else
        tick_cnt_q <= tick_cnt_q + 8'h01;
    end
  end

  // successive approximation: the msb weight is tried first, and each bit tick
  // keeps or drops the weight under test before trying the next lower one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_idx_q <= MSB_INDEX;
      trial_q   <= '0;
    end else if (clk_en) begin
      if (launch) begin
        bit_idx_q <= 5'(BITS - 1);
        trial_q   <= BITS'(CODE_MID);
      end else if (bit_tick) begin
        trial_q <= next_trial;
        if (!last_bit)
          bit_idx_q <= lower_idx;
      end
    end
  end

  // ground switches closed only while tracking; they open on the launch edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gnd_sw_q <= 1'b1;
    end else if (clk_en) begin
      gnd_sw_q <= will_sleep;
    end
  end

  // arrays leave the inputs one settle time after the switches have opened
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      to_in_q <= 1'b1;
    end else if (clk_en) begin
      to_in_q <= will_sleep || will_open;
    end
  end

  // converter power follows activity, so idle cost scales with the start rate
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_q <= 1'b0;
    end else if (clk_en) begin
      pwr_q <= !will_sleep;
    end
  end

  // busy spans launch to the final decision; later start edges cannot retrigger it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
    end else if (clk_en) begin
      if (launch)
        busy_q <= 1'b1;
      else if (final_tick)
        busy_q <= 1'b0;
    end
  end

  // completion pulse, one enabled cycle wide
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= final_tick;
    end
  end

  // code is written only at the end of its own conversion, never from a later sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= '0;
    end else if (clk_en) begin
      if (final_tick)
        code_q <= final_code;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // both ground switches move together; every output is a plain register copy
  assign pos_array_ground_switch = gnd_sw_q;
  assign neg_array_ground_switch = gnd_sw_q;
  assign array_to_input          = to_in_q;
  assign dac_bits                = trial_q;
  assign conv_power_on           = pwr_q;
  assign busy                    = busy_q;
  assign conv_done               = done_q;
  assign result_code             = code_q;

endmodule // sar_conversion_sequencer

// [verification/sar_seq_checker.sv]
`timescale 1ns/10ps
module sar_seq_checker
  import sar_seq_pkg::*;
#(
  parameter int unsigned BITS   = 16,
  parameter int unsigned DIV    = 2,
  parameter int unsigned SETTLE = 2
) (
  input wire logic            clk,
  input wire logic            reset_n,
  input wire logic            clk_en,
  input wire logic            convert_start_input,
  input wire logic            over_range,
  input wire logic            under_range,
  input wire logic            pos_array_ground_switch,
  input wire logic            neg_array_ground_switch,
  input wire logic            array_to_input,
  input wire logic [BITS-1:0] dac_bits,
  input wire logic            conv_power_on,
  input wire logic            busy,
  input wire logic            conv_done,
  input wire logic [BITS-1:0] result_code
);
  // busy rise to done pulse, no clk_en stall assumed
  localparam int DONE_LAG = 2 * SETTLE + BITS * DIV;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // start edge taken only in true idle, the done cycle still refuses
  a_start_taken: assert property (clk_en && $past(clk_en) && $rose(convert_start_input) && !busy && !conv_done
    && !$past(conv_done) |=> busy && conv_power_on && !pos_array_ground_switch && !neg_array_ground_switch)
    else $error("start edge not taken");
  a_msb_first: assert property ($rose(busy) |-> dac_bits == CODE_MID) else $error("first trial not msb");
  a_done_time: assert property ($rose(busy) |-> ##DONE_LAG conv_done) else $error("done not on time");
  a_busy_hold: assert property ($rose(busy) |=> busy[*8]) else $error("busy dropped early");
  a_done_back: assert property (conv_done |-> !busy ##1 !conv_done && pos_array_ground_switch
    && neg_array_ground_switch && array_to_input && !conv_power_on) else $error("no return to acquisition");
  a_idle_off: assert property (!busy && !conv_done |-> !conv_power_on) else $error("power on while idle");
  a_open_first: assert property ($fell(array_to_input) |-> $past(pos_array_ground_switch, 2) == 1'h0
    && $past(neg_array_ground_switch, 2) == 1'h0) else $error("arrays moved before switches opened");
  a_over_clamp: assert property (conv_done && over_range |-> result_code == CODE_FULL) else $error("no top clamp");
  a_under_clamp: assert property (conv_done && under_range && !over_range |-> result_code == CODE_ZERO)
    else $error("no bottom clamp");
  a_result_hold: assert property (!conv_done |-> $stable(result_code)) else $error("result moved");
endmodule // sar_seq_checker

// [verification/sar_front_model.sv]
`timescale 1ns/10ps
module sar_front_model (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic [15:0] vin,
  input  wire logic        ovr_in,
  input  wire logic        und_in,
  input  wire logic [15:0] dac_bits,
  output logic             comp_above,
  output logic             over_range,
  output logic             under_range
);
  logic [15:0] held_q;
  // track while idle; freeze at the taken edge so later input moves cannot leak in
  always @(posedge clk) begin
    if (!busy) begin
      held_q      <= vin;
      over_range  <= ovr_in;
      under_range <= und_in;
    end
  end
  assign comp_above = dac_bits > held_q;
endmodule // sar_front_model

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import sar_seq_pkg::*;
  logic        clk = 1'h0, reset_n = 1'h0, clk_en = 1'h1, convert_start_input = 1'h0, ovr = 1'h0, und = 1'h0;
  logic        comp_above, over_range, under_range, pos_array_ground_switch, neg_array_ground_switch;
  logic        array_to_input, conv_power_on, busy, conv_done;
  logic [15:0] vin = 16'h0000, dac_bits, result_code;
  logic [15:0] tbl [5] = '{16'h0000, 16'h8000, 16'hffff, 16'h7fff, 16'h0001};
  logic [15:0] exp_q [$];
  int          bad_count = 0, checks_done = 0, cycles = 0;
  sar_conversion_sequencer sar_conversion_sequencer_inst (.clk, .reset_n, .clk_en, .convert_start_input,
    .comp_above, .over_range, .under_range, .pos_array_ground_switch, .neg_array_ground_switch,
    .array_to_input, .dac_bits, .conv_power_on, .busy, .conv_done, .result_code);
  sar_front_model sar_front_model_inst (.clk, .busy, .vin, .ovr_in(ovr), .und_in(und), .dac_bits,
    .comp_above, .over_range, .under_range);
  always #10 clk = ~clk;
  // cycle ceiling well above the fourteen conversions started here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one conversion; input moves and a second start edge land mid-conversion
  task automatic convert(input logic [15:0] v, input logic o, input logic u);
    int n;
    @(posedge clk);
    vin <= v;
    ovr <= o;
    und <= u;
    convert_start_input <= 1'h1;
    exp_q.push_back(o ? CODE_FULL : (u ? CODE_ZERO : v));
    n = 0;
    while (busy !== 1'h1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    vin <= ~v;
    convert_start_input <= 1'h0;
    @(posedge clk);
    convert_start_input <= 1'h1;
    n = 0;
    while (conv_done !== 1'h1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    check(result_code, exp_q.pop_front());
    @(posedge clk);
    convert_start_input <= 1'h0;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hb026));
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    foreach (tbl[i]) convert(tbl[i], 1'h0, 1'h0);
    repeat (4) convert(16'($urandom), 1'h0, 1'h0);
    convert(16'h1234, 1'h1, 1'h0);
    convert(16'h1234, 1'h0, 1'h1);
    convert(16'h5555, 1'h1, 1'h1);
    // frozen clock enable must hold off a start edge
    @(posedge clk);
    clk_en <= 1'h0;
    convert_start_input <= 1'h1;
    repeat (4) @(posedge clk);
    #1 check({15'h0000, busy}, 16'h0000);
    @(posedge clk);
    clk_en <= 1'h1;
    // start stays high: the edge held off by the frozen enable launches now
    // reset in mid-conversion, then a clean conversion
    repeat (8) @(posedge clk);
    reset_n <= 1'h0;
    @(posedge clk);
    check({12'h000, pos_array_ground_switch, array_to_input, conv_power_on, busy}, 16'h000c);
    reset_n <= 1'h1;
    convert_start_input <= 1'h0;
    convert(16'hc3a5, 1'h0, 1'h0);
    print_verdict();
  end
endmodule // tb_top
bind sar_conversion_sequencer sar_seq_checker #(.BITS(BITS), .DIV(DIV), .SETTLE(SETTLE)) sar_seq_checker_inst (
  .clk, .reset_n, .clk_en, .convert_start_input, .over_range, .under_range, .pos_array_ground_switch,
  .neg_array_ground_switch, .array_to_input, .dac_bits, .conv_power_on, .busy, .conv_done, .result_code);
